// ==== acs_pkg.sv ====
// shared constants and types for the converter serial control link
package acs_pkg;

  // word and frame sizes
  localparam int unsigned WORD_W = 16;  // configuration and result width
  localparam int unsigned FRAME_BITS = 32;  // result then config readback
  localparam int unsigned RD_CNT_W = 6;  // read bit counter width
  localparam int unsigned WR_CNT_W = 5;  // write bit counter width

  // configuration word layout and reset value
  localparam logic [15:0] CFG_DEFAULT = 16'h0000;  // value after reset
  localparam int unsigned CFG_SEC_EN_BIT = 0;  // secondary output enable

  // synchroniser depth for inputs from another domain
  localparam int unsigned SYNC_STAGES = 3;

  // clock period of both ends' system clock
  localparam int unsigned CLK_PERIOD_NS = 100;

  // conversion duration (least time, rounded up)
  localparam int unsigned CONV_TIME_NS = 2000;
  localparam int unsigned CONV_CYCLES =
    (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // convert pulse high time issued by the host
  localparam int unsigned CNV_HIGH_NS = 100;
  localparam int unsigned CNV_HIGH_CYCLES =
    (CNV_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset pin high pulse width
  localparam int unsigned RST_PULSE_NS = 5;
  localparam int unsigned RST_PULSE_CYCLES =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reset pin quiet time after power-down release
  localparam int unsigned RST_LOW_NS = 100;
  localparam int unsigned RST_LOW_CYCLES =
    (RST_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // reference start-up wait after power-down release
  localparam int unsigned PWRUP_MS = 100;
  localparam int unsigned PWRUP_CYCLES =
    (PWRUP_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // host sequencer states
  typedef enum logic [2:0] {
    HS_OFF, HS_PWRUP, HS_IDLE, HS_RESET,
    HS_CNV, HS_WAIT_HI, HS_WAIT_LO, HS_FRAME
  } acs_host_state_e;

endpackage

// ==== acs_link_if.sv ====
// link pins between the converter control and its host
`timescale 1ns/1ps
interface acs_link_if;
  // serial clock, made by the host
  logic sck;
  // active-low bus select
  logic cs_n;
  // configuration data into the device
  logic din;
  // conversion start, reset and power-down pins
  logic convert_start;
  logic reset_pin;
  logic power_down_pin;
  // primary result output and its drive enable
  logic primary_serial_out;
  logic primary_serial_oe;
  // busy indication or secondary result output
  logic busy_or_secondary_out;

  // device end
  modport dev (
    input sck, cs_n, din, convert_start, reset_pin, power_down_pin,
    output primary_serial_out, primary_serial_oe, busy_or_secondary_out
  );

  // host end
  modport host (
    output sck, cs_n, din, convert_start, reset_pin, power_down_pin,
    input primary_serial_out, primary_serial_oe, busy_or_secondary_out
  );
endinterface

// ==== acs_device.sv ====
// converter end: conversion sequencing, config register and serial port
//
// Functional notes
// - serial port active only while select low
// - host uses select on shared bus
// - 16-bit config shifted in on rising clock
// - new config applied at end of conversion
// - config taken in first 16 clocks
// - host never shifts during a conversion
// - reset pin rise aborts, restores default config
// - power-down pin high holds minimum-current state
// - host waits start-up, then dummy conversion
// - reset pin stays low after power-up
// - result on primary output, falling edges
// - busy shown on shared pin while deselected
// - shared pin carries result when enabled
// - convert rising edge starts a conversion
// - result and config update at conversion end
// - 16 falls result, 16 more config
`timescale 1ns/1ps
module acs_device #(
  parameter int unsigned CONV_CYC = acs_pkg::CONV_CYCLES
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to the host
  acs_link_if.dev link,
  // converter core side
  input wire logic [acs_pkg::WORD_W-1:0] sample_data,
  output logic conv_sample,
  output logic busy,
  output logic [acs_pkg::WORD_W-1:0] cfg_active,
  output logic powered_down
);
  import acs_pkg::*;

  localparam int unsigned CNT_W = $clog2(CONV_CYC + 1);
  localparam logic [CNT_W-1:0] CONV_LAST = CNT_W'(CONV_CYC - 1);
  localparam logic [WR_CNT_W-1:0] WR_LAST = WR_CNT_W'(WORD_W - 1);
  localparam logic [WR_CNT_W-1:0] WR_DONE = WR_CNT_W'(WORD_W);
  localparam logic [RD_CNT_W-1:0] RD_DONE = RD_CNT_W'(FRAME_BITS);

  // link-side signals
  logic frame_clr;  // clears frame counters while deselected
  logic [WR_CNT_W-1:0] wr_cnt;  // config bits taken this frame
  logic [WORD_W-2:0] wr_sh;  // config bits gathered so far
  logic [WORD_W-1:0] cfg_shadow;  // last complete config word
  logic cfg_tgl;  // flips once per complete config word
  logic [RD_CNT_W-1:0] rd_cnt;  // falling edges seen this frame
  logic [FRAME_BITS-1:0] rd_word;  // result followed by config
  logic out_bit;  // bit presented on the outputs

  // system-side signals
  logic [3:0] async_in;  // inputs from outside the clk domain
  logic [3:0] lvl;  // filtered levels
  logic [3:0] chg;  // one-cycle change events
  logic [3:0] rise;  // one-cycle rising events
  logic cnv_rise;  // convert edge seen
  logic rst_rise;  // reset pin edge seen
  logic cfg_arrive;  // a new config word is waiting
  logic start_ok;  // a conversion may start now
  logic eoc;  // last cycle of a conversion
  logic [CNT_W-1:0] conv_cnt;  // cycles into the conversion
  logic [WORD_W-1:0] result;  // held conversion result
  logic [WORD_W-1:0] pend_cfg;  // config waiting for conversion end
  logic pend_valid;  // pend_cfg holds an unapplied word

  // crossing of pins and the config toggle into the clk domain
  assign async_in = {cfg_tgl, link.power_down_pin, link.reset_pin, link.convert_start};

  // one three-stage synchroniser and filter per input
  for (genvar i = 0; i < 4; i++) begin : g_sync
    logic [SYNC_STAGES-1:0] sh;  // sh[0] feeds sh[1] only
    logic stable;  // level once two late stages agree

    // shift and filter: a change counts when stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        sh <= '0;
        stable <= 1'b0;
      end else begin
        sh <= {sh[SYNC_STAGES-2:0], async_in[i]};
        if (sh[1] == sh[2]) begin
          stable <= sh[2];
        end
      end
    end

    assign lvl[i] = stable;
    assign chg[i] = (sh[1] == sh[2]) && (sh[2] != stable);
    assign rise[i] = chg[i] && sh[2];
  end

  assign cnv_rise = rise[0];
  assign rst_rise = rise[1];
  assign cfg_arrive = chg[3];
  assign powered_down = lvl[2];

  // a start needs an edge, no conversion running, no reset, no power-down
  assign start_ok = cnv_rise && !busy && !rst_rise && !powered_down;
  assign eoc = busy && (conv_cnt == CONV_LAST) && !rst_rise && !powered_down;

  // conversion sequencing

  // busy runs from the convert edge to the end of conversion
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy <= 1'b0;
      conv_cnt <= '0;
    end else if (rst_rise || powered_down) begin
      // reset edge or power-down aborts a running conversion
      busy <= 1'b0;
      conv_cnt <= '0;
    end else if (start_ok) begin
      busy <= 1'b1;
      conv_cnt <= '0;
    end else if (busy) begin
      if (conv_cnt == CONV_LAST) begin
        busy <= 1'b0;
      end else begin
        conv_cnt <= conv_cnt + 1'b1;
      end
    end
  end

  // strobe to the analog core to take a sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_sample <= 1'b0;
    end else begin
      conv_sample <= start_ok;
    end
  end

  // result register, loaded only at conversion end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= '0;
    end else if (eoc) begin
      result <= sample_data;
    end
  end

  // configuration register

  // pending word: an arriving word beats a same-cycle consumption
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_cfg <= CFG_DEFAULT;
      pend_valid <= 1'b0;
    end else if (rst_rise) begin
      pend_valid <= 1'b0;
    end else if (cfg_arrive) begin
      // shadow word has been still since the toggle flipped
      pend_cfg <= cfg_shadow;
      pend_valid <= 1'b1;
    end else if (eoc) begin
      pend_valid <= 1'b0;
    end
  end

  // active config: default on reset edge, new word at conversion end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_active <= CFG_DEFAULT;
    end else if (rst_rise) begin
      cfg_active <= CFG_DEFAULT;
    end else if (eoc && pend_valid) begin
      cfg_active <= pend_cfg;
    end
  end

  // serial port, clocked by the host's serial clock

  // counters clear whenever the port is deselected
  assign frame_clr = link.cs_n | ~rst_n;

  // write side: take the first 16 bits of a frame on rising edges
  always_ff @(posedge link.sck or posedge frame_clr) begin
    if (frame_clr) begin
      wr_cnt <= '0;
      wr_sh <= '0;
    end else if (wr_cnt != WR_DONE) begin
      wr_sh <= {wr_sh[WORD_W-3:0], link.din};
      wr_cnt <= wr_cnt + 1'b1;
    end
  end

  // complete word: hold it and flip the toggle for the clk domain
  always_ff @(posedge link.sck or negedge rst_n) begin
    if (!rst_n) begin
      cfg_shadow <= CFG_DEFAULT;
      cfg_tgl <= 1'b0;
    end else if (!link.cs_n && wr_cnt == WR_LAST) begin
      cfg_shadow <= {wr_sh, link.din};
      cfg_tgl <= ~cfg_tgl;
    end
  end

  // read side: count falling edges up to a full frame
  always_ff @(negedge link.sck or posedge frame_clr) begin
    if (frame_clr) begin
      rd_cnt <= '0;
    end else if (rd_cnt != RD_DONE) begin
      rd_cnt <= rd_cnt + 1'b1;
    end
  end

  // result and config are held still from conversion end onward
  assign rd_word = {result, cfg_active};

  // select one held bit; zeros once the frame is spent
  assign out_bit = rd_cnt[5] ? 1'b0 : rd_word[5'd31 - rd_cnt[4:0]];

  // primary output drives only while selected
  assign link.primary_serial_out = out_bit;
  assign link.primary_serial_oe = ~link.cs_n;

  // shared pin: data when selected and enabled, busy otherwise
  assign link.busy_or_secondary_out =
    (!link.cs_n && cfg_active[CFG_SEC_EN_BIT]) ? out_bit : busy;

endmodule // acs_device

// ==== acs_host.sv ====
// host end: power sequencing, convert pulses and serial frames
`timescale 1ns/1ps
module acs_host #(
  parameter int unsigned PWRUP_CYC = acs_pkg::PWRUP_CYCLES
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link to the device
  acs_link_if.host link,
  // user requests
  input wire logic start,
  input wire logic reset_req,
  input wire logic pd_req,
  input wire logic [acs_pkg::WORD_W-1:0] cfg_word,
  // user answers
  output logic ready,
  output logic done,
  output logic [acs_pkg::WORD_W-1:0] result,
  output logic [acs_pkg::WORD_W-1:0] cfg_readback
);
  import acs_pkg::*;

  localparam logic [31:0] PWRUP_LAST = 32'(PWRUP_CYC - 1);
  localparam logic [31:0] CNV_LAST = 32'(CNV_HIGH_CYCLES - 1);
  localparam logic [31:0] RST_LAST = 32'(RST_PULSE_CYCLES - 1);
  localparam logic [31:0] FRAME_LAST = 32'(FRAME_BITS);

  acs_host_state_e state;  // sequencer state
  logic [31:0] cnt;  // shared timer and bit counter
  logic [WORD_W-1:0] tx;  // config bits still to send
  logic [FRAME_BITS-1:0] rx;  // bits gathered from the device
  logic dummy;  // current conversion is the start-up dummy
  logic [SYNC_STAGES-1:0] busy_sh;  // busy synchroniser
  logic busy_s;  // filtered busy level

  // busy comes from the device clock domain: three stages and filter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_sh <= '0;
      busy_s <= 1'b0;
    end else begin
      busy_sh <= {busy_sh[SYNC_STAGES-2:0], link.busy_or_secondary_out};
      if (busy_sh[1] == busy_sh[2]) begin
        busy_s <= busy_sh[2];
      end
    end
  end

  assign ready = (state == HS_IDLE);

  // sequencer: power, reset pulses, convert pulses and frames
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= HS_OFF;
      cnt <= '0;
      tx <= '0;
      rx <= '0;
      dummy <= 1'b0;
      done <= 1'b0;
      result <= '0;
      cfg_readback <= '0;
      link.sck <= 1'b0;
      link.cs_n <= 1'b1;
      link.din <= 1'b0;
      link.convert_start <= 1'b0;
      link.reset_pin <= 1'b0;
      link.power_down_pin <= 1'b1;
    end else begin
      done <= 1'b0;
      if (pd_req && state != HS_OFF) begin
        // power-down wins over any activity
        state <= HS_OFF;
        link.power_down_pin <= 1'b1;
        link.cs_n <= 1'b1;
        link.sck <= 1'b0;
        link.convert_start <= 1'b0;
        link.reset_pin <= 1'b0;
      end else begin
        case (state)
          HS_OFF: begin
            // held high while the user keeps power-down asked
            if (!pd_req) begin
              link.power_down_pin <= 1'b0;
              cnt <= '0;
              state <= HS_PWRUP;
            end
          end
          HS_PWRUP: begin
            // reset pin stays low through the reference wait
            if (cnt >= PWRUP_LAST && cnt >= 32'(RST_LOW_CYCLES)) begin
              dummy <= 1'b1;
              link.convert_start <= 1'b1;
              cnt <= '0;
              state <= HS_CNV;
            end else begin
              cnt <= cnt + 32'd1;
            end
          end
          HS_IDLE: begin
            if (reset_req) begin
              link.reset_pin <= 1'b1;
              cnt <= '0;
              state <= HS_RESET;
            end else if (start) begin
              link.convert_start <= 1'b1;
              cnt <= '0;
              state <= HS_CNV;
            end
          end
          HS_RESET: begin
            // short high pulse on the reset pin
            if (cnt >= RST_LAST) begin
              link.reset_pin <= 1'b0;
              state <= HS_IDLE;
            end else begin
              cnt <= cnt + 32'd1;
            end
          end
          HS_CNV: begin
            // hold convert high, then wait for busy
            if (cnt >= CNV_LAST) begin
              link.convert_start <= 1'b0;
              state <= HS_WAIT_HI;
            end else begin
              cnt <= cnt + 32'd1;
            end
          end
          HS_WAIT_HI: begin
            if (busy_s) begin
              state <= HS_WAIT_LO;
            end
          end
          HS_WAIT_LO: begin
            // no serial activity until the conversion is over
            if (!busy_s) begin
              link.cs_n <= 1'b0;
              link.din <= cfg_word[WORD_W-1];
              tx <= {cfg_word[WORD_W-2:0], 1'b0};
              cnt <= '0;
              state <= HS_FRAME;
            end
          end
          HS_FRAME: begin
            // serial clock runs at half the system clock
            if (!link.sck) begin
              // rising edge: device takes din, host takes the output
              link.sck <= 1'b1;
              rx <= {rx[FRAME_BITS-2:0], link.primary_serial_out};
              cnt <= cnt + 32'd1;
            end else begin
              // falling edge: both sides present their next bit
              link.sck <= 1'b0;
              if (cnt == FRAME_LAST) begin
                link.cs_n <= 1'b1;
                link.din <= 1'b0;
                result <= rx[FRAME_BITS-1:WORD_W];
                cfg_readback <= rx[WORD_W-1:0];
                done <= !dummy;
                dummy <= 1'b0;
                state <= HS_IDLE;
              end else begin
                link.din <= tx[WORD_W-1];
                tx <= {tx[WORD_W-2:0], 1'b0};
              end
            end
          end
          default: begin
            state <= HS_IDLE;
          end
        endcase
      end
    end
  end

endmodule // acs_host

// ==== acs_link_monitor.sv ====
// link checker: timing relations on the link pins in both directions
`timescale 1ns/1ps
module acs_link_monitor (
  // host clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link pins
  input wire logic sck,
  input wire logic cs_n,
  input wire logic din,
  input wire logic convert_start,
  input wire logic reset_pin,
  input wire logic power_down_pin,
  input wire logic primary_serial_out,
  input wire logic primary_serial_oe,
  input wire logic busy_or_secondary_out
);
  import acs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // sck rises seen in the current frame
  logic [6:0] rises;
  // previous sampled sck level
  logic sck_q;
  // count rises while selected, clear while deselected
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rises <= 7'h00;
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
      if (cs_n) begin  // idle bus
        rises <= 7'h00;
      end else if (sck && !sck_q) begin  // a new rise
        rises <= rises + 7'h01;
      end
    end
  end
  a_oe_tracks_select: assert property (primary_serial_oe == !cs_n)
    else $error("primary drive enable differs from select");
  a_sck_quiet_idle: assert property (cs_n |-> !sck)
    else $error("serial clock moves while deselected");
  a_din_held_high: assert property (sck |-> $stable(din))
    else $error("config data changes while serial clock high");
  a_frame_bit_count: assert property ($rose(cs_n) && !power_down_pin |-> rises == FRAME_BITS)
    else $error("frame length wrong");
  a_select_after_eoc: assert property ($fell(cs_n) |-> $past(!busy_or_secondary_out))
    else $error("frame opened while busy");
  a_convert_sets_busy: assert property ($rose(convert_start) |-> ##[1:2] busy_or_secondary_out)
    else $error("busy missing after convert edge");
  a_busy_ends_bounded: assert property ($rose(busy_or_secondary_out) && cs_n |-> ##[1:3] !busy_or_secondary_out)
    else $error("busy lasts too long");
  a_convert_pulse_one: assert property ($rose(convert_start) |-> ##1 !convert_start)
    else $error("convert pulse too long");
  a_reset_drops_busy: assert property ($rose(reset_pin) |-> ##[0:1] !busy_or_secondary_out)
    else $error("busy survives reset pin");
  a_reset_quiet_pwrup: assert property ($fell(power_down_pin) |-> !reset_pin ##1 !reset_pin)
    else $error("reset pin raised right after power-up");
  a_pd_link_idle: assert property (power_down_pin |-> cs_n && !convert_start)
    else $error("link active during power-down");
  // main scenarios reached
  c_frame_end: cover property ($rose(cs_n));
  c_power_up: cover property ($fell(power_down_pin));
  c_reset_pin: cover property ($rose(reset_pin));
endmodule  // acs_link_monitor

// ==== adc_serial_conversion_control_tb.sv ====
// self-checking bench: host and device ends joined over the link
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  total_checks++; \
  if ((got) !== (exp)) begin \
    mismatches++; \
    $display("Error at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module adc_serial_conversion_control_tb;
  import acs_pkg::*;
  // clocks and reset
  logic clk;
  logic dclk;
  logic rst_n;
  // host user side
  logic start;
  logic reset_req;
  logic pd_req;
  logic [WORD_W-1:0] cfg_word;
  logic ready;
  logic done;
  logic [WORD_W-1:0] result;
  logic [WORD_W-1:0] cfg_readback;
  // device core side
  logic [WORD_W-1:0] sample_data;
  logic conv_sample;
  logic busy;
  logic [WORD_W-1:0] cfg_active;
  logic powered_down;
  // bench state
  int mismatches;
  int total_checks;
  int cycles;
  int n;
  int n_conv;
  logic [31:0] seed;
  logic [WORD_W-1:0] pending;  // word due at the next conversion end
  logic [FRAME_BITS-1:0] out_cap;  // primary output bits of a frame
  logic [FRAME_BITS-1:0] din_cap;  // config bits of a frame
  logic exp_pin;  // expected shared pin level
  acs_link_if link ();
  acs_host #(.PWRUP_CYC(50)) acs_host_i (.clk(clk), .rst_n(rst_n), .link(link),
    .start(start), .reset_req(reset_req), .pd_req(pd_req), .cfg_word(cfg_word),
    .ready(ready), .done(done), .result(result), .cfg_readback(cfg_readback));
  // a 42-cycle conversion spans two to three host clocks, so the filtered busy is seen
  acs_device #(.CONV_CYC(42)) acs_device_i (.clk(dclk), .rst_n(rst_n), .link(link),
    .sample_data(sample_data), .conv_sample(conv_sample), .busy(busy),
    .cfg_active(cfg_active), .powered_down(powered_down));
  acs_link_monitor acs_link_monitor_i (.clk(clk), .rst_n(rst_n), .sck(link.sck),
    .cs_n(link.cs_n), .din(link.din), .convert_start(link.convert_start),
    .reset_pin(link.reset_pin), .power_down_pin(link.power_down_pin),
    .primary_serial_out(link.primary_serial_out), .primary_serial_oe(link.primary_serial_oe),
    .busy_or_secondary_out(link.busy_or_secondary_out));
  // host clock, 100 ns
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // device clock, 6 ns, offset phase
  initial begin
    dclk = 1'b0;
    #1.7;
    forever #3 dclk = ~dclk;
  end
  // shared pin shows data only when selected and the word in effect enables it
  assign exp_pin = (!link.cs_n && pending[CFG_SEC_EN_BIT]) ? link.primary_serial_out : busy;
  always @(negedge dclk) begin
    if (rst_n === 1'b1) begin
      `CHK(link.busy_or_secondary_out, exp_pin)  // shared pin
    end
  end
  // frame bits taken where the host samples them
  always @(posedge link.sck) begin
    if (!link.cs_n) begin
      out_cap <= {out_cap[FRAME_BITS-2:0], link.primary_serial_out};
      din_cap <= {din_cap[FRAME_BITS-2:0], link.din};
    end
  end
  // count accepted conversions
  always @(posedge dclk) begin
    if (conv_sample === 1'b1) begin
      n_conv++;
    end
  end
  // hang guard
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      conclude();
    end
  end
  // next pseudo-random value
  function automatic logic [31:0] next_rand(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    next_rand = x ^ (x << 5);
  endfunction
  // expected frame: result then applied config, msb first
  function automatic logic [FRAME_BITS-1:0] exp_frame(input logic [15:0] r, input logic [15:0] c);
    exp_frame = {r, c};
  endfunction
  // wait for the host to go idle, bounded
  task automatic wait_ready(output int k);
    k = 0;
    while (ready !== 1'b1 && k < 2000) begin
      @(negedge clk);
      k++;
    end
  endtask
  // one conversion and frame with its checks
  task automatic convert(input logic [WORD_W-1:0] sd, input logic [WORD_W-1:0] cw);
    int k;
    int c0;
    wait_ready(k);
    c0 = n_conv;
    sample_data = sd;
    cfg_word = cw;
    start = 1'b1;
    @(negedge clk);
    start = 1'b0;
    k = 0;
    while (done !== 1'b1 && k < 500) begin
      @(negedge clk);
      k++;
    end
    `CHK(done, 1'b1)  // frame completes
    `CHK(n_conv, c0 + 1)  // one conversion per edge
    `CHK(result, sd)  // twos complement result
    `CHK(out_cap, exp_frame(sd, pending))  // wire order
    `CHK(cfg_readback, pending)  // readback of applied word
    `CHK(cfg_active, pending)  // new word waits for next end
    `CHK(din_cap[FRAME_BITS-1:WORD_W], cw)  // first 16 bits are config
    pending = cw;
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    reset_req = 1'b0;
    pd_req = 1'b0;
    cfg_word = 16'h0001;
    sample_data = 16'h0000;
    mismatches = 0;
    total_checks = 0;
    cycles = 0;
    n_conv = 0;
    seed = 32'd86703;
    pending = CFG_DEFAULT;
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    `CHK(cfg_active, CFG_DEFAULT)  // default config
    // the start-up dummy frame shifts in the first config word
    wait_ready(n);
    pending = cfg_word;
    convert(16'h8000, 16'hfffe);
    convert(16'h7fff, 16'h0001);
    convert(16'hffff, 16'h0001);
    for (int i = 0; i < 12; i++) begin
      seed = next_rand(seed);
      convert(seed[15:0], seed[31:16]);
    end
    // reset pin restores default and drops the pending word
    wait_ready(n);
    reset_req = 1'b1;
    @(negedge clk);
    reset_req = 1'b0;
    repeat (3) @(negedge clk);
    `CHK(cfg_active, CFG_DEFAULT)  // default after reset pin
    pending = CFG_DEFAULT;
    convert(16'h1234, 16'h0001);
    // power-down, then start-up wait and dummy conversion
    pd_req = 1'b1;
    repeat (4) @(negedge clk);
    `CHK(powered_down, 1'b1)  // low-current state
    `CHK(ready, 1'b0)  // no conversions while down
    pd_req = 1'b0;
    wait_ready(n);
    `CHK((n >= 50), 1'b1)  // start-up wait honoured
    pending = cfg_word;
    convert(16'h5a5a, 16'h0000);
    convert(16'ha5a5, 16'h0001);
    conclude();
  end
endmodule  // adc_serial_conversion_control_tb
